// *** common/aosr_defines.vh ***
// Register offsets, field positions and reset values for the accelerometer output/status bank
`ifndef AOSR_DEFINES_VH
`define AOSR_DEFINES_VH

`define AOSR_ADDR_REVISION 8'h00
`define AOSR_ADDR_STATUS 8'h02
`define AOSR_ADDR_AXIS_BASE 8'h04
`define AOSR_ADDR_AXIS_LAST 8'h09
`define AOSR_ADDR_TEMP_LO 8'h12
`define AOSR_ADDR_TEMP_HI 8'h13
`define AOSR_ADDR_COUNT 8'h15
`define AOSR_ADDR_INTFLAGS 8'h16
`define AOSR_ADDR_RING 8'h0f

`define AOSR_ZERO8 8'h00
`define AOSR_BIT_FULL 7
`define AOSR_BIT_HALF 6
`define AOSR_BIT_FREEFALL 3
`define AOSR_BIT_LOCK 5
`define AOSR_BIT_CSUM 1
`define AOSR_BIT_FRAME 0
`define AOSR_MODE_MOTION 3'h3

`endif

// *** hdl/aosr_ring_mem.v ***
// Small sample memory holding ring-buffer axis words, registered read port
`timescale 1ns/10ps
`default_nettype none
module aosr_ring_mem #(
	parameter WIDTH = 13,
	parameter DEPTH = 64,
	parameter AW = 6
) (
	input wire clk_sys,
	input wire wrEn,
	input wire [AW-1:0] wrAddr,
	input wire [WIDTH-1:0] wrData,
	input wire [AW-1:0] rdAddr,
	output reg [WIDTH-1:0] rdData
);
	reg [WIDTH-1:0] memArray [0:DEPTH-1];

	////////////////////////////////////////////////////////////////
	// Write and registered read; no reset so it maps to block RAM
	always @(posedge clk_sys) begin
		if (wrEn) begin
			memArray[wrAddr] <= wrData;
		end
		rdData <= memArray[rdAddr];
	end
endmodule
`default_nettype wire

// *** hdl/aosr_output_status.v ***
// Output and status register bank of a three-axis accelerometer
//
// Notes on behaviour
// - Direct axis word: sign in high bit 7, 12-bit magnitude, low bits 2..0 zero.
// - Ring 11-bit format: sign, d9..d0 over high byte and low bits 7..5.
// - Ring 8-bit format: one byte, sign then d6..d0.
// - Temperature: 9-bit unsigned, t8..t3 high bits 5..0, t2..t0 low 7..5.
// - Sample count register, read only, zero after reset.
// - Interrupt bit 7 set while buffer at least three-quarters full.
// - Interrupt bit 6 set while buffer at least half full.
// - Interrupt bit 3 shows detected free-fall.
// - Interrupt bits 2..0 show motion triggers Y, X, Z; several may coexist.
// - Interrupt register shows only conditions existing in the current mode.
// - Fixed revision byte: major in bits 7..4, minor in bits 3..0.
// - Status bit 5 shows lock open, zero after reset.
// - Status bit 1 flags nonvolatile checksum failure.
// - Status bit 0 flags bad serial frame, cleared by next good frame.
// - Temperature, count, interrupt and status registers read only, zero after reset.
// - Mode bit 6 selects one byte per stored axis, else two bytes.
`timescale 1ns/10ps
`default_nettype none
`include "aosr_defines.vh"
module aosr_output_status #(
	parameter MAJOR_REV = 4'h1,
	parameter MINOR_REV = 4'h0,
	parameter RING_DEPTH = 64,
	parameter RING_AW = 6
) (
	input wire clk_sys,
	input wire rst_n,
	// Core-side measurement inputs, same clock domain
	input wire [12:0] axisX,
	input wire [12:0] axisY,
	input wire [12:0] axisZ,
	input wire axisValid,
	input wire [8:0] tempValue,
	input wire tempValid,
	input wire ringShortFormat,
	input wire [2:0] opMode,
	input wire freefallEnable,
	input wire freefallDetect,
	input wire [2:0] motionTriggerAxes,
	// Ring feed and drain from the core
	input wire ringPush,
	input wire [12:0] ringPushData,
	input wire ringPop,
	// Status sources, levels and one-cycle frame pulses
	input wire lockOpen,
	input wire nvmChecksumError,
	input wire frameBad,
	input wire frameGood,
	// Register read port from the serial interface
	input wire rdStrobe,
	input wire [7:0] rdAddr,
	// Host writes arrive here but change nothing
	input wire wrStrobe,
	input wire [7:0] wrAddr,
	input wire [7:0] wrData,
	output reg [7:0] rdData_reg,
	output reg rdValid_reg
);
	////////////////////////////////////////////////////////////////
	// Reset release through two flops
	// Assertion acts at once, release waits for two clean edges
	reg rstSync1_reg;
	reg rstSync2_reg;
	wire rstInt_n;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1_reg <= 1'b0;
			rstSync2_reg <= 1'b0;
		end else begin
			rstSync1_reg <= 1'b1;
			rstSync2_reg <= rstSync1_reg;
		end
	end
	assign rstInt_n = rstSync2_reg;

	////////////////////////////////////////////////////////////////
	// Captured measurement words
	reg [12:0] axisHold_reg [0:2];
	reg [8:0] temp_reg;
	wire [38:0] axisIn;
	assign axisIn = {axisZ, axisY, axisX};
	genvar gi;
	// Each axis holds its last sample until the next valid strobe
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : gAxis
			always @(posedge clk_sys or negedge rstInt_n) begin
				if (!rstInt_n) begin
					axisHold_reg[gi] <= 13'h0000;
				end else if (axisValid) begin
					axisHold_reg[gi] <= axisIn[gi*13 +: 13];
				end
			end
		end
	endgenerate

	// Temperature holds zero until the first conversion
	always @(posedge clk_sys or negedge rstInt_n) begin
		if (!rstInt_n) begin
			temp_reg <= 9'h000;
		end else if (tempValid) begin
			temp_reg <= tempValue;
		end
	end

	////////////////////////////////////////////////////////////////
	// Ring buffer pointers and sample count
	reg [RING_AW-1:0] wrPtr_reg;
	reg [RING_AW-1:0] rdPtr_reg;
	reg [7:0] count_reg;
	wire doPush;
	wire doPop;
	wire [12:0] ringWord;
	// Fill thresholds worked out once at full width, then cut to the count width
	localparam [31:0] DEPTH32 = RING_DEPTH;
	localparam [31:0] HALF32 = RING_DEPTH / 2;
	localparam [31:0] THREEQ32 = (RING_DEPTH * 3) / 4;
	// An eight-bit count limits the ring to 255 entries
	localparam [7:0] DEPTH8 = DEPTH32[7:0];
	localparam [7:0] HALF8 = HALF32[7:0];
	localparam [7:0] THREEQ8 = THREEQ32[7:0];
	// Push into a full ring is dropped to keep the count honest
	assign doPush = ringPush && (count_reg != DEPTH8);
	assign doPop = ringPop && (count_reg != `AOSR_ZERO8);
	always @(posedge clk_sys or negedge rstInt_n) begin
		if (!rstInt_n) begin
			wrPtr_reg <= {RING_AW{1'b0}};
			rdPtr_reg <= {RING_AW{1'b0}};
			count_reg <= `AOSR_ZERO8;
		end else begin
			if (doPush) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (doPop) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
			// Simultaneous push and pop leave the count unchanged
			if (doPush && !doPop) begin
				count_reg <= count_reg + 8'h01;
			end else if (doPop && !doPush) begin
				count_reg <= count_reg - 8'h01;
			end
		end
	end

	// Memory read is registered, so the word lags a pop by one cycle
	aosr_ring_mem #(
		.WIDTH(13),
		.DEPTH(RING_DEPTH),
		.AW(RING_AW)
	) uRingMem (
		.clk_sys(clk_sys),
		.wrEn(doPush),
		.wrAddr(wrPtr_reg),
		.wrData(ringPushData),
		.rdAddr(rdPtr_reg),
		.rdData(ringWord)
	);

	////////////////////////////////////////////////////////////////
	// Interrupt flags, mode gated
	reg [7:0] intFlags_reg;
	reg [7:0] intFlags_next;
	wire inMotionMode;
	assign inMotionMode = (opMode == `AOSR_MODE_MOTION);
	wire ringHalf;
	wire ringThreeQuarter;
	// Levels, not latched events: they drop as soon as the ring drains
	assign ringHalf = (count_reg >= HALF8);
	assign ringThreeQuarter = (count_reg >= THREEQ8);
	always @* begin
		intFlags_next = `AOSR_ZERO8;
		intFlags_next[`AOSR_BIT_FULL] = ringThreeQuarter;
		intFlags_next[`AOSR_BIT_HALF] = ringHalf;
		// Free-fall only reported when detection is enabled
		intFlags_next[`AOSR_BIT_FREEFALL] = freefallEnable && freefallDetect;
		// Motion axes only exist in motion detector mode
		if (inMotionMode) begin
			intFlags_next[2:0] = motionTriggerAxes;
		end
	end
	always @(posedge clk_sys or negedge rstInt_n) begin
		if (!rstInt_n) begin
			intFlags_reg <= `AOSR_ZERO8;
		end else begin
			intFlags_reg <= intFlags_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status register
	reg [7:0] status_reg;
	always @(posedge clk_sys or negedge rstInt_n) begin
		if (!rstInt_n) begin
			status_reg <= `AOSR_ZERO8;
		end else begin
			// Lock and checksum are plain levels, copied every cycle
			status_reg[`AOSR_BIT_LOCK] <= lockOpen;
			status_reg[`AOSR_BIT_CSUM] <= nvmChecksumError;
			// A bad frame wins over a good one in the same cycle
			if (frameBad) begin
				status_reg[`AOSR_BIT_FRAME] <= 1'b1;
			end else if (frameGood) begin
				status_reg[`AOSR_BIT_FRAME] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Ring read sequencing: low byte follows high byte in long format
	reg ringSecond_reg;
	reg ringSecond_next;
	wire ringAddrHit;
	assign ringAddrHit = rdStrobe && (rdAddr == `AOSR_ADDR_RING);
	// The core drains the ring; a host read only steps the byte phase
	always @* begin
		ringSecond_next = ringSecond_reg;
		if (ringAddrHit) begin
			if (ringShortFormat) begin
				ringSecond_next = 1'b0;
			end else begin
				ringSecond_next = !ringSecond_reg;
			end
		end
	end
	always @(posedge clk_sys or negedge rstInt_n) begin
		if (!rstInt_n) begin
			ringSecond_reg <= 1'b0;
		end else begin
			ringSecond_reg <= ringSecond_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Ring byte formats built from the stored 13-bit word
	wire [7:0] ringHighByte;
	wire [7:0] ringLowByte;
	wire [7:0] ringShortByte;
	// Long format drops the two lowest magnitude bits, short format five
	assign ringHighByte = {ringWord[12], ringWord[11:5]};
	assign ringLowByte = {ringWord[4:2], 5'h00};
	assign ringShortByte = {ringWord[12], ringWord[11:5]};

	////////////////////////////////////////////////////////////////
	// Direct axis bytes, one pair per axis
	wire [23:0] axisHighBytes;
	wire [23:0] axisLowBytes;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : gAxisBytes
			wire [12:0] axisWord;
			assign axisWord = axisHold_reg[gi];
			assign axisHighBytes[gi*8 +: 8] = {axisWord[12], axisWord[11:5]};
			assign axisLowBytes[gi*8 +: 8] = {axisWord[4:0], 3'h0};
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Direct axis address decode: even address low byte, odd high byte
	wire axisAddrHit;
	wire [7:0] axisOffset;
	wire [1:0] axisIdx;
	wire axisHighSel;
	reg [7:0] axisByte;
	assign axisAddrHit = (rdAddr >= `AOSR_ADDR_AXIS_BASE) && (rdAddr <= `AOSR_ADDR_AXIS_LAST);
	assign axisOffset = rdAddr - `AOSR_ADDR_AXIS_BASE;
	// Two addresses per axis, so the halved offset is the axis index
	assign axisIdx = axisOffset[2:1];
	assign axisHighSel = axisOffset[0];
	always @* begin
		axisByte = `AOSR_ZERO8;
		case (axisIdx)
			2'h0: begin
				axisByte = axisHighSel ? axisHighBytes[7:0] : axisLowBytes[7:0];
			end
			2'h1: begin
				axisByte = axisHighSel ? axisHighBytes[15:8] : axisLowBytes[15:8];
			end
			2'h2: begin
				axisByte = axisHighSel ? axisHighBytes[23:16] : axisLowBytes[23:16];
			end
			default: begin
				axisByte = `AOSR_ZERO8;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Fixed and temperature bytes
	wire [7:0] revisionByte;
	wire [7:0] tempHighByte;
	wire [7:0] tempLowByte;
	// Revision is wired in, so it reads the same before and after reset
	assign revisionByte = {MAJOR_REV[3:0], MINOR_REV[3:0]};
	assign tempHighByte = {2'b00, temp_reg[8:3]};
	assign tempLowByte = {temp_reg[2:0], 5'h00};

	////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped addresses read zero
	reg [7:0] rdMux;
	always @* begin
		rdMux = `AOSR_ZERO8;
		case (rdAddr)
			`AOSR_ADDR_REVISION: rdMux = revisionByte;
			`AOSR_ADDR_STATUS: rdMux = status_reg;
			`AOSR_ADDR_TEMP_HI: rdMux = tempHighByte;
			`AOSR_ADDR_TEMP_LO: rdMux = tempLowByte;
			`AOSR_ADDR_COUNT: rdMux = count_reg;
			`AOSR_ADDR_INTFLAGS: rdMux = intFlags_reg;
			`AOSR_ADDR_RING: begin
				if (ringShortFormat) begin
					rdMux = ringShortByte;
				end else if (!ringSecond_reg) begin
					rdMux = ringHighByte;
				end else begin
					rdMux = ringLowByte;
				end
			end
			default: begin
				if (axisAddrHit) begin
					rdMux = axisByte;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Registered read answer, one cycle after the strobe
	always @(posedge clk_sys or negedge rstInt_n) begin
		if (!rstInt_n) begin
			rdData_reg <= `AOSR_ZERO8;
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= rdStrobe;
			// Data holds between reads so a slow host can still pick it up
			if (rdStrobe) begin
				rdData_reg <= rdMux;
			end
		end
	end
	// Writes to this bank have no effect: wrStrobe, wrAddr and wrData are unused
endmodule
`default_nettype wire

// *** test/aosr_output_status_assertions.sv ***
// Concurrent checks on the read port of the output/status bank
`timescale 1ns/10ps
`default_nettype none
module aosr_output_status_assertions (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic rdStrobe,
	input wire logic [7:0] rdAddr,
	input wire logic lockOpen,
	input wire logic [7:0] rdData_reg,
	input wire logic rdValid_reg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// Reads answered one edge later, nothing else answers
	chk_read_answer: assert property (rdStrobe |=> rdValid_reg)
		else $error("read not answered");
	chk_no_extra: assert property (!rdStrobe |=> !rdValid_reg)
		else $error("answer without read");
	// Fixed fields and unused bits of the revision, temperature, axis low, status and interrupt registers
	chk_rev_byte: assert property (rdStrobe && rdAddr == 8'h00 |=> rdData_reg == 8'h10)
		else $error("revision byte wrong");
	chk_temp_high: assert property (rdStrobe && rdAddr == 8'h13 |=> rdData_reg[7:6] == 2'h0)
		else $error("temperature high unused bits set");
	chk_temp_low: assert property (rdStrobe && rdAddr == 8'h12 |=> rdData_reg[4:0] == 5'h00)
		else $error("temperature low unused bits set");
	chk_axis_low: assert property (rdStrobe && rdAddr inside {8'h04, 8'h06, 8'h08}
		|=> rdData_reg[2:0] == 3'h0)
		else $error("axis low unused bits set");
	chk_status_rsv: assert property (rdStrobe && rdAddr == 8'h02
		|=> rdData_reg[7:6] == 2'h0 && rdData_reg[4:2] == 3'h0)
		else $error("status reserved bits set");
	chk_int_rsv: assert property (rdStrobe && rdAddr == 8'h16 |=> rdData_reg[5:4] == 2'h0)
		else $error("interrupt reserved bits set");
	// Only a settled lock level is compared, so flag latency does not matter
	chk_lock_bit: assert property (rdStrobe && rdAddr == 8'h02 && lockOpen == $past(lockOpen)
		|=> rdData_reg[5] == $past(lockOpen))
		else $error("lock bit wrong");
endmodule
bind aosr_output_status aosr_output_status_assertions i_chk (.*);
`default_nettype wire

// *** test/aosr_host_model.sv ***
// Host model issuing register reads and writes to the bank
`timescale 1ns/10ps
`default_nettype none
module aosr_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] rdData_reg,
	input wire logic rdValid_reg,
	output logic rdStrobe,
	output logic [7:0] rdAddr,
	output logic wrStrobe,
	output logic [7:0] wrAddr,
	output logic [7:0] wrData
);
	// Idle bus
	initial begin
		rdStrobe = 1'b0;
		wrStrobe = 1'b0;
		rdAddr = 8'h00;
		wrAddr = 8'h00;
		wrData = 8'h00;
	end
	// One-edge strobe, then at most four edges of waiting
	task automatic readReg(input logic [7:0] a, output logic [7:0] d, output logic late);
		int i;
		@(posedge clk_sys);
		#1;
		rdStrobe = 1'b1;
		rdAddr = a;
		@(posedge clk_sys);
		#1;
		rdStrobe = 1'b0;
		rdAddr = ~a; // Released address must not look valid
		i = 0;
		while (rdValid_reg !== 1'b1 && i < 4) begin
			@(posedge clk_sys);
			#1;
			i++;
		end
		d = rdData_reg;
		late = (rdValid_reg !== 1'b1);
	endtask
	// Writes carry no answer
	task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		wrStrobe = 1'b1;
		wrAddr = a;
		wrData = d;
		@(posedge clk_sys);
		#1;
		wrStrobe = 1'b0;
		wrData = ~d;
	endtask
endmodule
`default_nettype wire

// *** test/aosr_output_status_test.sv ***
// Self-checking bench for the output/status register bank
`timescale 1ns/10ps
`default_nettype none
module aosr_output_status_test;
	logic clk_sys = 1'b0, rst_n = 1'b0, axisValid = 1'b0, tempValid = 1'b0;
	logic ringShortFormat = 1'b0, freefallEnable = 1'b0, freefallDetect = 1'b0;
	logic ringPush = 1'b0, ringPop = 1'b0, lockOpen = 1'b0, nvmChecksumError = 1'b0;
	logic frameBad = 1'b0, frameGood = 1'b0;
	logic [12:0] axisX = 13'h1abc, axisY = 13'h0a5a, axisZ = 13'h1234, ringPushData = 13'h0000;
	logic [8:0] tempValue = 9'h1ab;
	logic [2:0] opMode = 3'h0, motionTriggerAxes = 3'h0;
	wire logic rdStrobe, wrStrobe, rdValid_reg;
	wire logic [7:0] rdAddr, wrAddr, wrData, rdData_reg;
	logic [7:0] roRegs [4] = '{8'h02, 8'h12, 8'h13, 8'h16};
	int fails = 0, n_checks = 0;
	always #20 clk_sys = ~clk_sys;
	// Short ring so fill levels are reached quickly
	aosr_output_status #(.RING_DEPTH(8), .RING_AW(3)) i_dut (.*);
	aosr_host_model i_host (.*);
	////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] reg %h expected %h seen %h", a, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic late;
		i_host.readReg(a, d, late);
		if (late) begin
			fails++;
			summarize();
		end
		chk(a, d, e);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		step(5);
		rst_n = 1'b1;
		step(3);
		// Reset values; writes and unmapped reads give nothing
		rd(8'h00, 8'h10);
		rd(8'h15, 8'h00);
		for (int k = 0; k < 4; k++) begin
			i_host.writeReg(roRegs[k], 8'hff);
			rd(roRegs[k], 8'h00);
		end
		i_host.writeReg(8'h00, 8'h5a);
		rd(8'h00, 8'h10);
		rd(8'h30, 8'h00);
		// Captured temperature and axis words
		tempValid = 1'b1;
		axisValid = 1'b1;
		step(1);
		tempValid = 1'b0;
		axisValid = 1'b0;
		step(1);
		rd(8'h13, 8'h35);
		rd(8'h12, 8'h60);
		rd(8'h05, 8'hd5);
		rd(8'h04, 8'he0);
		rd(8'h07, 8'h52);
		rd(8'h06, 8'hd0);
		rd(8'h09, 8'h91);
		rd(8'h08, 8'ha0);
		// Fill past the top; the ninth push is dropped; stored words differ only in bits 7..5
		for (int k = 0; k < 9; k++) begin
			ringPushData = 13'h0a1c + 13'(k * 32);
			ringPush = 1'b1;
			step(1);
			ringPush = 1'b0;
			step(1);
			if (k == 3) rd(8'h16, 8'h40);
			if (k == 5) rd(8'h16, 8'hc0);
		end
		rd(8'h15, 8'h08);
		rd(8'h0f, 8'h50);
		rd(8'h0f, 8'he0);
		ringPop = 1'b1;
		ringShortFormat = 1'b1;
		step(1);
		ringPop = 1'b0;
		step(1);
		rd(8'h0f, 8'h51);
		rd(8'h15, 8'h07);
		// Free-fall and motion flags, then leave motion mode
		freefallEnable = 1'b1;
		freefallDetect = 1'b1;
		opMode = 3'h3;
		motionTriggerAxes = 3'h5;
		step(2);
		rd(8'h16, 8'hcd);
		opMode = 3'h0;
		step(2);
		rd(8'h16, 8'hc8);
		freefallEnable = 1'b0;
		step(2);
		rd(8'h16, 8'hc0);
		// Status flags; a good frame clears the frame error
		lockOpen = 1'b1;
		nvmChecksumError = 1'b1;
		frameBad = 1'b1;
		step(1);
		frameBad = 1'b0;
		step(2);
		rd(8'h02, 8'h23);
		frameGood = 1'b1;
		step(1);
		frameGood = 1'b0;
		step(2);
		rd(8'h02, 8'h22);
		summarize();
	end
endmodule
`default_nettype wire
